// [prc_pkg.sv]
// Package of constants and rate tables for the primary rate clock configuration block.
// Operation
// - Six-bit rate select; zero means auto-detect.
// - Codes 1-40 fix rate; 41-63 reserved.
// - Fixed code accepts frames only within range.
// - Tolerance bit picks 1% or 5% detection.
// - Clock-setup bit picks automatic or custom clocking.
// - Register at 0x32 resets to 0x00.
package prc_pkg;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PRC_CFG0_ADDR    = 8'h32;
    localparam logic [7:0] PRC_CFG0_RESET   = 8'h00;
    localparam int         PRC_SEL_LSB      = 2;
    localparam int         PRC_SEL_MSB      = 7;
    localparam int         PRC_TOL_BIT      = 1;
    localparam int         PRC_CUSTOM_BIT   = 0;
    localparam logic [5:0] PRC_SEL_AUTO     = 6'h00;
    localparam int         PRC_NUM_CODES    = 40;
    localparam logic [5:0] PRC_LAST_CODE    = 6'h28;

    // ----------------------------------------------------------------
    // Timing and measurement
    // ----------------------------------------------------------------
    localparam int unsigned PRC_SYS_CLK_HZ  = 100_000_000;
    localparam int          PRC_CNT_W       = 16;
    localparam logic [15:0] PRC_CNT_MAX     = 16'hffff;
    localparam logic [1:0]  PRC_EDGES_VALID = 2'h2;
    localparam int unsigned PRC_TOL_NARROW  = 1;
    localparam int unsigned PRC_TOL_WIDE    = 5;

    // ----------------------------------------------------------------
    // Rate tables in Hz, index 1 is code 1
    // ----------------------------------------------------------------
    localparam int unsigned PRC_RATE_TYP [1:40] = '{
        768000, 614400, 512000, 438857, 384000, 341333, 307200, 256000,
        219429, 192000, 170667, 153600, 128000, 109714, 96000, 85333,
        76800, 64000, 54857, 48000, 42667, 38400, 32000, 27429,
        24000, 21333, 19200, 16000, 13714, 12000, 10667, 9600,
        8000, 6857, 6000, 5333, 4800, 4000, 3429, 3000};
    localparam int unsigned PRC_RATE_LO [1:40] = '{
        670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440,
        191520, 167580, 148960, 134064, 111720, 95760, 83790, 74480,
        67032, 55860, 47880, 41895, 37240, 33516, 27930, 23940,
        20947, 18620, 16758, 13965, 11970, 10473, 9310, 8379,
        6982, 5985, 5236, 4655, 4189, 3491, 2992, 2618};
    localparam int unsigned PRC_RATE_HI [1:40] = '{
        791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680,
        226011, 197760, 175786, 158208, 131840, 113005, 98880, 87893,
        79104, 65920, 56502, 49440, 43946, 39552, 32950, 28251,
        24720, 21973, 19776, 16480, 14125, 12360, 10986, 9888,
        8240, 7062, 6180, 5493, 4944, 4120, 3531, 3090};

    // Frame period in system clocks, rounded down, for a rate in Hz.
    function automatic int unsigned prc_period_floor(input int unsigned rate);
        return PRC_SYS_CLK_HZ / rate;
    endfunction : prc_period_floor

    // Frame period in system clocks, rounded up, for a rate in Hz.
    function automatic int unsigned prc_period_ceil(input int unsigned rate);
        return (PRC_SYS_CLK_HZ + rate - 1) / rate;
    endfunction : prc_period_ceil

endpackage : prc_pkg

// [prc_rate_match.sv]
// Per-code comparison of a measured frame period against the rate table.
`timescale 1ns/1ps
module prc_rate_match
(
    input  wire logic [15:0] period_i,
    input  wire logic        tol_wide_i,
    output logic      [39:0] in_range_o,
    output logic      [39:0] std_hit_o
);

    // ----------------------------------------------------------------
    // Three comparator pairs per code
    // ----------------------------------------------------------------
    // Bounds are fixed at elaboration, so each code costs only two
    // 17-bit compares per check instead of a divider in hardware.
    genvar g;
    generate
        for (g = 1; g <= prc_pkg::PRC_NUM_CODES; g++)
        begin : g_code
            localparam int unsigned PMIN = prc_pkg::prc_period_ceil(prc_pkg::PRC_RATE_HI[g]);
            localparam int unsigned PMAX = prc_pkg::prc_period_floor(prc_pkg::PRC_RATE_LO[g]);
            localparam int unsigned PTYP = prc_pkg::prc_period_floor(prc_pkg::PRC_RATE_TYP[g]);
            localparam int unsigned N_LO = PTYP * (100 - prc_pkg::PRC_TOL_NARROW) / 100;
            localparam int unsigned N_HI = PTYP * (100 + prc_pkg::PRC_TOL_NARROW) / 100;
            localparam int unsigned W_LO = PTYP * (100 - prc_pkg::PRC_TOL_WIDE) / 100;
            localparam int unsigned W_HI = PTYP * (100 + prc_pkg::PRC_TOL_WIDE) / 100;
            localparam logic [16:0] MIN17 = 17'(PMIN);
            localparam logic [16:0] MAX17 = 17'(PMAX);
            localparam logic [16:0] NLO17 = 17'(N_LO);
            localparam logic [16:0] NHI17 = 17'(N_HI);
            localparam logic [16:0] WLO17 = 17'(W_LO);
            localparam logic [16:0] WHI17 = 17'(W_HI);
            logic [16:0] p17;
            assign p17 = {1'b0, period_i};
            // Allowed range of a fixed code.
            assign in_range_o[g-1] = (p17 >= MIN17) && (p17 <= MAX17);
            // Standard-rate window used by auto-detection.
            assign std_hit_o[g-1] = tol_wide_i ? ((p17 >= WLO17) && (p17 <= WHI17))
                                               : ((p17 >= NLO17) && (p17 <= NHI17));
        end
    endgenerate

endmodule : prc_rate_match

// [prc_clock_config.sv]
// Primary rate clock configuration register with frame rate detection and divider choice.
`timescale 1ns/1ps
module prc_clock_config
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        frame_sync_i,
    input  wire logic [15:0] custom_div_i,
    output logic      [5:0]  rate_code_o,
    output logic             rate_valid_o,
    output logic             rate_fault_o,
    output logic             custom_clk_o,
    output logic      [15:0] clk_div_o
);

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] rdata_q;
    logic [5:0] primary_rate_select;
    logic       rate_tolerance_widen;
    logic       custom_clk_cfg;

    // All eight bits are writable; reserved codes are stored as written
    // so software reads back exactly what it wrote.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            cfg_q <= prc_pkg::PRC_CFG0_RESET;
        end
        else if (reg_wr_i && (reg_addr_i == prc_pkg::PRC_CFG0_ADDR))
        begin
            cfg_q <= reg_wdata_i;
        end
    end

    // Read data is registered; other addresses belong to other blocks
    // and read as zero from this one.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (reg_rd_i && (reg_addr_i == prc_pkg::PRC_CFG0_ADDR))
        begin
            rdata_q <= cfg_q;
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    // Field split of the register.
    assign primary_rate_select  = cfg_q[prc_pkg::PRC_SEL_MSB:prc_pkg::PRC_SEL_LSB];
    assign rate_tolerance_widen = cfg_q[prc_pkg::PRC_TOL_BIT];
    assign custom_clk_cfg       = cfg_q[prc_pkg::PRC_CUSTOM_BIT];
    assign reg_rdata_o          = rdata_q;

    // ----------------------------------------------------------------
    // Frame sync synchroniser
    // ----------------------------------------------------------------
    logic fs_meta_q;
    logic fs_sync_q;
    logic fs_prev_q;
    logic fs_rise;

    // The pin is asynchronous; only fs_sync_q and its delayed copy fs_prev_q are looked at by logic.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            fs_meta_q <= 1'b0;
            fs_sync_q <= 1'b0;
            fs_prev_q <= 1'b0;
        end
        else
        begin
            fs_meta_q <= frame_sync_i;
            fs_sync_q <= fs_meta_q;
            fs_prev_q <= fs_sync_q;
        end
    end

    assign fs_rise = fs_sync_q & ~fs_prev_q;

    // ----------------------------------------------------------------
    // Frame period measurement
    // ----------------------------------------------------------------
    logic [15:0] cnt_q;
    logic [15:0] period_q;
    logic [1:0]  edges_q;
    logic        meas_ok;

    // Counts system clocks between frame starts. The counter saturates
    // so a stopped frame clock cannot wrap into a false period.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            cnt_q    <= 16'h0000;
            period_q <= 16'h0000;
        end
        else if (fs_rise)
        begin
            cnt_q    <= 16'h0001;
            period_q <= cnt_q;
        end
        else if (cnt_q != prc_pkg::PRC_CNT_MAX)
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // A period is trusted after two frame starts; a stall drops it again.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            edges_q <= 2'h0;
        end
        else if (!fs_rise && (cnt_q == prc_pkg::PRC_CNT_MAX))
        begin
            edges_q <= 2'h0;
        end
        else if (fs_rise && (edges_q != prc_pkg::PRC_EDGES_VALID))
        begin
            edges_q <= edges_q + 2'h1;
        end
    end

    assign meas_ok = (edges_q == prc_pkg::PRC_EDGES_VALID);

    // ----------------------------------------------------------------
    // Rate table comparison
    // ----------------------------------------------------------------
    logic [39:0] in_range;
    logic [39:0] std_hit;

    prc_rate_match u_match
    (
        .period_i   (period_q),
        .tol_wide_i (rate_tolerance_widen),
        .in_range_o (in_range),
        .std_hit_o  (std_hit)
    );

    // ----------------------------------------------------------------
    // Active rate selection
    // ----------------------------------------------------------------
    logic [5:0] code_d;
    logic       valid_d;
    logic       fault_d;

    // Auto mode takes the fastest standard rate whose window holds the
    // measured period; the windows do not overlap at 1%, and at 5% the
    // higher rate wins a tie.
    always_comb
    begin
        code_d  = 6'h00;
        valid_d = 1'b0;
        fault_d = 1'b0;
        if (primary_rate_select == prc_pkg::PRC_SEL_AUTO)
        begin
            for (int i = prc_pkg::PRC_NUM_CODES; i >= 1; i--)
            begin
                if (std_hit[i-1] && meas_ok)
                begin
                    code_d  = 6'(i);
                    valid_d = 1'b1;
                end
            end
            fault_d = meas_ok && !valid_d;
        end
        else if (primary_rate_select <= prc_pkg::PRC_LAST_CODE)
        begin
            code_d  = primary_rate_select;
            valid_d = meas_ok && in_range[primary_rate_select - 6'h01];
            fault_d = meas_ok && !valid_d;
        end
        else
        begin
            // Reserved codes never lock; software must not use them.
            fault_d = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Clock divider choice
    // ----------------------------------------------------------------
    logic [15:0] div_d;
    logic [15:0] auto_div;

    // The automatic divider is the nominal frame period of the active
    // code, so no other register needs writing in automatic mode.
    always_comb
    begin
        auto_div = 16'h0000;
        for (int i = 1; i <= prc_pkg::PRC_NUM_CODES; i++)
        begin
            if (code_d == 6'(i))
            begin
                auto_div = 16'(prc_pkg::prc_period_floor(prc_pkg::PRC_RATE_TYP[i]));
            end
        end
    end

    // Custom mode hands the divider over to software unchanged; the
    // block trusts that it was programmed before the switch.
    always_comb
    begin
        if (custom_clk_cfg)
        begin
            div_d = custom_div_i;
        end
        else
        begin
            div_d = auto_div;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    logic [5:0]  code_q;
    logic        valid_q;
    logic        fault_q;
    logic        custom_q;
    logic [15:0] div_q;

    // Status of the detector: rate code, valid and fault.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            code_q  <= 6'h00;
            valid_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            code_q  <= code_d;
            valid_q <= valid_d;
            fault_q <= fault_d;
        end
    end

    // Divider output; holds zero until a rate or custom value exists.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            custom_q <= 1'b0;
            div_q    <= 16'h0000;
        end
        else
        begin
            custom_q <= custom_clk_cfg;
            div_q    <= div_d;
        end
    end

    assign rate_code_o  = code_q;
    assign rate_valid_o = valid_q;
    assign rate_fault_o = fault_q;
    assign custom_clk_o = custom_q;
    assign clk_div_o    = div_q;

endmodule : prc_clock_config

// [prc_clock_config_monitor.sv]
// Concurrent checks on the ports of the primary rate clock configuration block.
`timescale 1ns/1ps
module prc_clock_config_monitor
(
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        frame_sync_i,
    input wire logic [15:0] custom_div_i,
    input wire logic [5:0]  rate_code_o,
    input wire logic        rate_valid_o,
    input wire logic        rate_fault_o,
    input wire logic        custom_clk_o,
    input wire logic [15:0] clk_div_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // One clock domain, so clocking and reset are given once here.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_wr_cfg;
        reg_wr_i && reg_addr_i == prc_pkg::PRC_CFG0_ADDR;
    endsequence
    sequence s_rd_cfg;
        reg_rd_i && !reg_wr_i && reg_addr_i == prc_pkg::PRC_CFG0_ADDR;
    endsequence

    // Reset itself is the cause here, so this one is not disabled by it.
    a_reset_clears: assert property (disable iff (1'b0) !rstn_i |=>
        reg_rdata_o == 8'h00 && rate_code_o == 6'h00 && !rate_valid_o
        && !rate_fault_o && !custom_clk_o && clk_div_o == 16'h0000)
        else $error("outputs not cleared by reset");
    a_write_readback: assert property (s_wr_cfg ##1 s_rd_cfg |=>
        reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback differs");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i != prc_pkg::PRC_CFG0_ADDR |=>
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_idle_rdata: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data without a read");
    a_custom_follow: assert property (s_wr_cfg |-> ##2
        custom_clk_o == $past(reg_wdata_i[0], 2)) else $error("custom bit lost");
    a_custom_div: assert property (custom_clk_o && $past(custom_clk_o)
        && $stable(custom_div_i) |-> clk_div_o == custom_div_i)
        else $error("custom divider not passed");
    a_valid_code: assert property (rate_valid_o |-> !rate_fault_o
        && rate_code_o inside {[6'd1:6'd40]}) else $error("bad valid code");
    a_auto_div: assert property (!custom_clk_o && !$past(custom_clk_o)
        && rate_code_o == 6'h01 |-> clk_div_o == 16'd130)
        else $error("auto divider wrong");
    a_code_zero: assert property (rate_code_o == 6'h00 |-> !rate_valid_o)
        else $error("valid without a code");
endmodule : prc_clock_config_monitor

bind prc_clock_config prc_clock_config_monitor u_mon (.clk_sys_i, .rstn_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .frame_sync_i,
    .custom_div_i, .rate_code_o, .rate_valid_o, .rate_fault_o, .custom_clk_o,
    .clk_div_o);

// [tb_primary_rate_clock_config.sv]
// Self-checking testbench for the primary rate clock configuration block.
`timescale 1ns/1ps
module tb_primary_rate_clock_config;
    // ------------------------------------------------------------
    // Signals and scoreboard
    // ------------------------------------------------------------
    localparam int NOM1 = 100_000_000 / 768000;
    logic        clk_sys_i    = 1'b0;
    logic        rstn_i       = 1'b0;
    logic [7:0]  reg_addr_i   = 8'h00;
    logic        reg_wr_i     = 1'b0;
    logic [7:0]  reg_wdata_i  = 8'h00;
    logic        reg_rd_i     = 1'b0;
    logic        frame_sync_i = 1'b0;
    logic [15:0] custom_div_i = 16'h0000;
    logic [7:0]  reg_rdata_o;
    logic [5:0]  rate_code_o;
    logic        rate_valid_o, rate_fault_o, custom_clk_o;
    logic [15:0] clk_div_o;
    logic [7:0]  rq[$];
    logic [24:0] sq[$];
    logic        rd_seen = 1'b0;
    logic        samp    = 1'b0;
    int          err_total = 0;
    int          checked   = 0;
    int          cycles    = 0;
    int unsigned seed;
    logic [7:0]  v;
    // Rows: config byte, frame period, expected code, valid and fault.
    logic [7:0]  cfg_t [7] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'ha4, 8'h05};
    int          per_t [7] = '{130, 160, 130, 134, 134, 130, 130};
    logic [5:0]  code_t [7] = '{6'h01, 6'h01, 6'h01, 6'h00, 6'h01, 6'h00, 6'h01};
    logic        v_t [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic        f_t [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic        custom_clk_exp = 1'b0;

    prc_clock_config uut (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
        .reg_rd_i, .reg_rdata_o, .frame_sync_i, .custom_div_i, .rate_code_o,
        .rate_valid_o, .rate_fault_o, .custom_clk_o, .clk_div_o);

    always #5 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [24:0] exp, input logic [24:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // Write then read on the next cycle, so the readback path is hit back to back.
    task wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        rq.push_back(e);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
    endtask : wrrd

    // Three rises give one clean period even after another rate ran before.
    task frames(input int p);
        repeat (3)
        begin
            frame_sync_i = 1'b1;
            repeat (p / 2) @(negedge clk_sys_i);
            frame_sync_i = 1'b0;
            repeat (p - p / 2) @(negedge clk_sys_i);
        end
    endtask : frames

    task stat(input logic [5:0] c, input logic vl, input logic f, input logic [15:0] d);
        repeat (4) @(negedge clk_sys_i);
        sq.push_back({c, vl, f, custom_clk_exp, d});
        samp = 1'b1;
        @(negedge clk_sys_i);
        samp = 1'b0;
    endtask : stat

    // Single read of one address; the watcher compares it on the following edge.
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        rq.push_back(e);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
    endtask : rd

    // ------------------------------------------------------------
    // Output watcher: oldest note is compared when a result appears
    // ------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (rd_seen)
            check("read data", {17'h0, rq.pop_front()}, {17'h0, reg_rdata_o});
        if (samp)
            check("rate status", sq.pop_front(), {rate_code_o, rate_valid_o,
                rate_fault_o, custom_clk_o, clk_div_o});
        rd_seen <= reg_rd_i;
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = $urandom(18);
        repeat (8) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        stat(6'h00, 1'b0, 1'b0, 16'h0000);
        rd(8'h32, 8'h00);
        wrrd(8'h33, 8'hff, 8'h00);
        wrrd(8'h32, 8'h00, 8'h00);
        repeat (8)
        begin
            // Random writes keep to legal select codes; one table row tries a reserved one.
            v = {6'($urandom_range(0, 40)), 2'($urandom_range(0, 3))};
            wrrd(8'h32, v, v);
        end
        // The divider is programmed before any row selects custom clocking.
        custom_div_i = 16'($urandom_range(1, 65535));
        for (int i = 0; i < 7; i++)
        begin
            wrrd(8'h32, cfg_t[i], cfg_t[i]);
            frames(per_t[i]);
            custom_clk_exp = cfg_t[i][0];
            stat(code_t[i], v_t[i], f_t[i], cfg_t[i][0] ? custom_div_i :
                (code_t[i] != 6'h00 ? 16'(NOM1) : 16'h0000));
        end
        // A second reset in mid-run must bring the register back to zero.
        @(negedge clk_sys_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        custom_clk_exp = 1'b0;
        rd(8'h32, 8'h00);
        wrrd(8'h30, 8'h11, 8'h00);
        stat(6'h00, 1'b0, 1'b0, 16'h0000);
        results();
    end
endmodule : tb_primary_rate_clock_config
